// ---- rtl/rifm_top.sv ----
/*
 * Resolver input fault monitor: qualifies analog comparator results with deglitch
 * counters, keeps sticky flags, drives a fault pin and cuts the exciter on overvoltage.
 * Assumes comparator outputs arrive asynchronously and an APB master on sys_clk.
 */
// The APB slave port and the placing of the registers were decided locally.
// Function
// - Each of the four sensor input pins has its own high and low overvoltage flag.
// - Short-to-ground and short-to-battery checks share one programmable deglitch.
// - Sine and cosine outputs against mutual-short thresholds set one mutual-short flag.
// - Sine and cosine open-input checks use their own deglitch and per-channel flags.
// - An open fault needs the output beyond threshold longer than the deglitch period.
// - Loop error beyond its limits past a programmable deglitch sets the loop flag.
// - Integrity check per pin against fixed levels with a fixed 5 us deglitch.
// - Reference duty above 80 percent sets duty-high, below 20 percent duty-low.
// - The duty fault is qualified by a programmable deglitch before flagging.
// - Either exciter output above 115 percent for 10 us disables the exciter.
// - Crossings shorter than the deglitch limit raise no fault.
// - Exciter diagnostics are suppressed for 10 ms after exciter enable.
// - Faults go to readable flags and a fault pin or disable the affected block.
`timescale 1ns/10ps
`default_nettype none

module rifm_top
    import rifm_pkg::*;
#(
    parameter int unsigned BLANK_CYC = EXC_BLANK_CYC,
    parameter int unsigned N_PINS    = 4
)(
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [N_PINS-1:0]  input_ov_high_cmp,
    input  wire logic [N_PINS-1:0]  input_ov_low_cmp,
    input  wire logic [N_PINS-1:0]  integrity_high_cmp,
    input  wire logic [N_PINS-1:0]  integrity_low_cmp,
    input  wire logic [1:0]         mutual_short_cmp,
    input  wire logic               sine_open_high_cmp,
    input  wire logic               cosine_open_high_cmp,
    input  wire logic               cosine_open_low_cmp,
    input  wire logic               loop_error_cmp,
    input  wire logic               ref_pulse,
    input  wire logic               exciter_sense_pos_ov,
    input  wire logic               exciter_sense_neg_ov,
    output logic                    exciter_out_en,
    output logic                    fault_irq
);
    localparam int unsigned N_SYNC    = 4 * N_PINS + 9;
    localparam int unsigned N_DG      = 4 * N_PINS + 9;
    localparam int unsigned BLK_W     = $clog2(BLANK_CYC + 1);
    localparam int unsigned WIN_W     = $clog2(DUTY_WIN_CYC + 1);
    // positions of the single-wire comparators in the sync vector, after the pin groups
    localparam int unsigned SYN_REF   = 4 * N_PINS + 6;
    localparam int unsigned SYN_EXC_P = 4 * N_PINS + 7;
    localparam int unsigned SYN_EXC_N = 4 * N_PINS + 8;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N_SYNC-1:0]  sync1;
        logic [N_SYNC-1:0]  sync2;
        logic [31:0]        ctrl;
        logic [31:0]        degl;
        logic [ST_W-1:0]    stat;
        logic [ST_W-1:0]    mask;
        logic [BLK_W-1:0]   blank_cnt;
        logic               blank_done;
        logic               exc_ov_trip;
        logic [WIN_W-1:0]   win_cnt;
        logic [WIN_W-1:0]   high_cnt;
        logic               duty_hi;
        logic               duty_lo;
        logic [31:0]        rdata;
        logic               irq;
    } rifm_state_t;

    rifm_state_t s_q;
    rifm_state_t s_d;

    // ------------------------------------------------------------
    // deglitch counters
    // ------------------------------------------------------------
    rifm_degl_if dg_if [N_DG] ();
    logic [N_DG-1:0] dg_fault;
    logic [N_DG-1:0] dg_cond;
    logic [DEGL_CNT_W-1:0] dg_lim [N_DG];

    function automatic logic [DEGL_CNT_W-1:0] sel_lim(input logic [DEGL_SEL_W-1:0] sel);
        sel_lim = DEGL_CNT_W'((32'(sel) + 1) * DEGL_STEP_CYC);
    endfunction

    genvar g;
    generate
        for (g = 0; g < N_DG; g++) begin : g_dg
            assign dg_if[g].cond  = dg_cond[g];
            assign dg_if[g].limit = dg_lim[g];
            assign dg_fault[g]    = dg_if[g].fault;
            rifm_deglitch u_dg (
                .sys_clk (sys_clk),
                .arst_n  (arst_n),
                .dg      (dg_if[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // synchronised comparator inputs
    // ------------------------------------------------------------
    // every comparator is asynchronous to sys_clk, so each passes two flops
    logic [N_SYNC-1:0] raw_in;
    logic [N_SYNC-1:0] syn;
    assign raw_in = {exciter_sense_neg_ov, exciter_sense_pos_ov, ref_pulse, loop_error_cmp,
                     cosine_open_low_cmp, cosine_open_high_cmp, sine_open_high_cmp,
                     mutual_short_cmp, integrity_low_cmp, integrity_high_cmp,
                     input_ov_low_cmp, input_ov_high_cmp};
    assign syn = s_q.sync2;

    // ------------------------------------------------------------
    // exciter diagnostics gate
    // ------------------------------------------------------------
    // the exciter output settles after enable, so its checks wait out the blank
    logic exc_en;
    logic exc_diag_on;
    assign exc_en      = s_q.ctrl[CTRL_EXC_EN_BIT];
    assign exc_diag_on = exc_en && s_q.blank_done;

    // ------------------------------------------------------------
    // condition and limit mapping
    // ------------------------------------------------------------
    always_comb begin
        dg_cond = '0;
        for (int i = 0; i < N_DG; i++) begin
            dg_lim[i] = '0;
        end
        for (int i = 0; i < 2 * N_PINS; i++) begin
            dg_cond[i] = syn[i];
            dg_lim[i]  = sel_lim(s_q.degl[DEGL_SHORT_POS +: DEGL_SEL_W]);
        end
        for (int i = 2 * N_PINS; i < 4 * N_PINS; i++) begin
            dg_cond[i] = syn[i];
            dg_lim[i]  = DEGL_CNT_W'(INTEG_DEGL_CYC);
        end
        for (int i = 0; i < 2; i++) begin
            dg_cond[4*N_PINS+i] = syn[4*N_PINS+i];
            dg_lim[4*N_PINS+i]  = sel_lim(s_q.degl[DEGL_MUTUAL_POS +: DEGL_SEL_W]);
        end
        for (int i = 2; i < 5; i++) begin
            dg_cond[4*N_PINS+i] = syn[4*N_PINS+i];
            dg_lim[4*N_PINS+i]  = sel_lim(s_q.degl[DEGL_OPEN_POS +: DEGL_SEL_W]);
        end
        dg_cond[4*N_PINS+5] = syn[4*N_PINS+5];
        dg_lim[4*N_PINS+5]  = sel_lim(s_q.degl[DEGL_LOOP_POS +: DEGL_SEL_W]);
        dg_cond[4*N_PINS+6] = s_q.duty_hi && exc_diag_on;
        dg_lim[4*N_PINS+6]  = sel_lim(s_q.degl[DEGL_DUTY_POS +: DEGL_SEL_W]);
        dg_cond[4*N_PINS+7] = s_q.duty_lo && exc_diag_on;
        dg_lim[4*N_PINS+7]  = sel_lim(s_q.degl[DEGL_DUTY_POS +: DEGL_SEL_W]);
        dg_cond[4*N_PINS+8] = (syn[SYN_EXC_P] || syn[SYN_EXC_N]) && exc_diag_on;
        dg_lim[4*N_PINS+8]  = DEGL_CNT_W'(EXC_OV_DEGL_CYC);
    end

    // ------------------------------------------------------------
    // event vector in status layout
    // ------------------------------------------------------------
    logic [ST_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[ST_SHORT_HI_POS +: 4] = dg_fault[0 +: 4];
        ev[ST_SHORT_LO_POS +: 4] = dg_fault[4 +: 4];
        ev[ST_INTEG_HI_POS +: 4] = dg_fault[8 +: 4];
        ev[ST_INTEG_LO_POS +: 4] = dg_fault[12 +: 4];
        // both channels share one mutual-short flag
        ev[ST_MUTUAL_POS]        = |dg_fault[16 +: 2];
        ev[ST_SIN_OPEN_POS]      = dg_fault[18];
        ev[ST_COS_OPEN_H_POS]    = dg_fault[19];
        ev[ST_COS_OPEN_L_POS]    = dg_fault[20];
        ev[ST_LOOP_POS]          = dg_fault[21];
        ev[ST_DUTY_HI_POS]       = dg_fault[22];
        ev[ST_DUTY_LO_POS]       = dg_fault[23];
        ev[ST_EXC_OV_POS]        = dg_fault[24];
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic acc;
    logic wr;
    logic mapped;
    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign mapped = (paddr == REG_CTRL_OFS) || (paddr == REG_DEGL_OFS) ||
                    (paddr == REG_STAT_OFS) || (paddr == REG_MASK_OFS) ||
                    (paddr == REG_LIVE_OFS);
    // no wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = s_q.rdata;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sync1 = raw_in;
        s_d.sync2 = s_q.sync1;

        if (wr && paddr == REG_CTRL_OFS) begin
            s_d.ctrl = pwdata;
        end
        if (wr && paddr == REG_DEGL_OFS) begin
            s_d.degl = pwdata;
        end
        if (wr && paddr == REG_MASK_OFS) begin
            s_d.mask = pwdata[ST_W-1:0];
        end
        // write one clears, but a new event in the same cycle wins
        s_d.stat = s_q.stat;
        if (wr && paddr == REG_STAT_OFS) begin
            s_d.stat = s_q.stat & ~pwdata[ST_W-1:0];
        end
        s_d.stat = s_d.stat | ev;

        // blanking after exciter enable
        if (!exc_en) begin
            s_d.blank_cnt  = '0;
            s_d.blank_done = 1'b0;
        end else if (!s_q.blank_done) begin
            if (32'(s_q.blank_cnt) >= BLANK_CYC - 1) begin
                s_d.blank_done = 1'b1;
            end else begin
                s_d.blank_cnt = s_q.blank_cnt + 1'b1;
            end
        end

        // overvoltage trip holds the exciter off until software re-enables it
        if (ev[ST_EXC_OV_POS]) begin
            s_d.exc_ov_trip = 1'b1;
            s_d.ctrl[CTRL_EXC_EN_BIT] = 1'b0;
        end else if (wr && paddr == REG_CTRL_OFS && pwdata[CTRL_EXC_EN_BIT]) begin
            s_d.exc_ov_trip = 1'b0;
        end

        // duty measured over a fixed window, verdict held for next window
        // a window that straddles a duty change can give a mixed verdict
        if (32'(s_q.win_cnt) >= DUTY_WIN_CYC - 1) begin
            s_d.win_cnt  = '0;
            s_d.high_cnt = '0;
            s_d.duty_hi  = 32'(s_q.high_cnt) * 100 > DUTY_HIGH_PCT * DUTY_WIN_CYC;
            s_d.duty_lo  = 32'(s_q.high_cnt) * 100 < DUTY_LOW_PCT * DUTY_WIN_CYC;
        end else begin
            s_d.win_cnt  = s_q.win_cnt + 1'b1;
            s_d.high_cnt = s_q.high_cnt + WIN_W'(syn[SYN_REF]);
        end
        if (!exc_diag_on) begin
            s_d.duty_hi = 1'b0;
            s_d.duty_lo = 1'b0;
        end

        s_d.rdata = '0;
        if (psel && !pwrite) begin
            unique case (paddr)
                REG_CTRL_OFS: s_d.rdata = s_q.ctrl;
                REG_DEGL_OFS: s_d.rdata = s_q.degl;
                REG_STAT_OFS: s_d.rdata = 32'(s_q.stat);
                REG_MASK_OFS: s_d.rdata = 32'(s_q.mask);
                REG_LIVE_OFS: s_d.rdata = {29'h0000_0000, s_q.exc_ov_trip,
                                           s_q.blank_done, exc_en};
                default:      s_d.rdata = '0;
            endcase
        end

        s_d.irq = |(s_d.stat & s_d.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q       <= '0;
            s_q.ctrl  <= CTRL_RST;
            s_q.degl  <= DEGL_RST;
            s_q.mask  <= MASK_RST[ST_W-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // drive stays off from the trip edge until software writes the enable again
    assign exciter_out_en = exc_en && !s_q.exc_ov_trip;
    assign fault_irq      = s_q.irq;
endmodule

`default_nettype wire

// ---- rtl/rifm_pkg.sv ----
/*
 * Package of the resolver input fault monitor: register offsets, field positions,
 * reset values and cycle counts derived from the 25 MHz system clock.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package rifm_pkg;

    // ------------------------------------------------------------
    // clock and fixed deglitch times
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ         = 25_000_000;
    localparam int unsigned INTEG_DEGL_NS      = 5_000;
    localparam int unsigned EXC_OV_DEGL_NS     = 10_000;
    localparam int unsigned EXC_BLANK_MS       = 10;
    localparam int unsigned INTEG_DEGL_CYC     = (INTEG_DEGL_NS * (SYS_CLK_HZ / 1_000_000)
                                                  + 999) / 1000;
    localparam int unsigned EXC_OV_DEGL_CYC    = (EXC_OV_DEGL_NS * (SYS_CLK_HZ / 1_000_000)
                                                  + 999) / 1000;
    localparam int unsigned EXC_BLANK_CYC      = EXC_BLANK_MS * (SYS_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // programmable deglitch: delay = (sel + 1) * step cycles
    // ------------------------------------------------------------
    localparam int unsigned DEGL_SEL_W         = 4;
    localparam int unsigned DEGL_STEP_CYC      = 25;
    localparam int unsigned DEGL_CNT_W         = 16;

    // ------------------------------------------------------------
    // duty measurement: window of reference samples, thresholds in percent
    // ------------------------------------------------------------
    localparam int unsigned DUTY_WIN_CYC       = 1000;
    localparam int unsigned DUTY_HIGH_PCT      = 80;
    localparam int unsigned DUTY_LOW_PCT       = 20;
    localparam int unsigned DUTY_NOM_PCT       = 50;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_OFS        = 8'h00;
    localparam logic [7:0] REG_DEGL_OFS        = 8'h04;
    localparam logic [7:0] REG_STAT_OFS        = 8'h08;
    localparam logic [7:0] REG_MASK_OFS        = 8'h0C;
    localparam logic [7:0] REG_LIVE_OFS        = 8'h10;

    // ctrl fields
    localparam int unsigned CTRL_EXC_EN_BIT    = 0;

    // deglitch select field positions
    localparam int unsigned DEGL_SHORT_POS     = 0;
    localparam int unsigned DEGL_MUTUAL_POS    = 4;
    localparam int unsigned DEGL_OPEN_POS      = 8;
    localparam int unsigned DEGL_LOOP_POS      = 12;
    localparam int unsigned DEGL_DUTY_POS      = 16;

    // status bit positions
    localparam int unsigned ST_SHORT_HI_POS    = 0;
    localparam int unsigned ST_SHORT_LO_POS    = 4;
    localparam int unsigned ST_INTEG_HI_POS    = 8;
    localparam int unsigned ST_INTEG_LO_POS    = 12;
    localparam int unsigned ST_MUTUAL_POS      = 16;
    localparam int unsigned ST_SIN_OPEN_POS    = 17;
    localparam int unsigned ST_COS_OPEN_H_POS  = 18;
    localparam int unsigned ST_COS_OPEN_L_POS  = 19;
    localparam int unsigned ST_LOOP_POS        = 20;
    localparam int unsigned ST_DUTY_HI_POS     = 21;
    localparam int unsigned ST_DUTY_LO_POS     = 22;
    localparam int unsigned ST_EXC_OV_POS      = 23;
    localparam int unsigned ST_W               = 24;

    localparam logic [31:0] CTRL_RST           = 32'h0000_0000;
    localparam logic [31:0] DEGL_RST           = 32'h0000_0000;
    localparam logic [31:0] MASK_RST           = 32'h0000_0000;

endpackage

// ---- rtl/rifm_degl_if.sv ----
/*
 * Interface between the monitor top and one deglitch counter.
 * Assumes both ends share sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

interface rifm_degl_if;
    import rifm_pkg::*;
    logic                   cond;
    logic [DEGL_CNT_W-1:0]  limit;
    logic                   fault;
    modport ctl (output cond, output limit, input fault);
    modport flt (input cond, input limit, output fault);
endinterface

`default_nettype wire

// ---- rtl/rifm_deglitch.sv ----
/*
 * One deglitch counter: counts while the condition holds, clears when it drops,
 * raises fault once the count reaches the limit.
 * Assumes cond is already synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module rifm_deglitch
    import rifm_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   arst_n,
    rifm_degl_if.flt    dg
);
    typedef struct packed {
        logic [DEGL_CNT_W-1:0] cnt;
    } rifm_dg_state_t;

    rifm_dg_state_t s_q;
    rifm_dg_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (!dg.cond) begin
            s_d.cnt = '0;
        end else if (s_q.cnt < dg.limit) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // a crossing shorter than limit never reaches it
    assign dg.fault = dg.cond && (s_q.cnt >= dg.limit);
endmodule

`default_nettype wire

// ---- dv/rifm_ref_model.sv ----
/* reference pulse comparator model for the monitor bench
   assumes duty_pct is a multiple of 5 */
`timescale 1ns/10ps
`default_nettype none
module rifm_ref_model (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic [6:0] duty_pct,
    output logic            ref_pulse
);
    logic [4:0] ph_q;
    // 20-cycle period keeps every duty step a whole count
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q      <= '0;
            ref_pulse <= 1'b0;
        end else begin
            ph_q      <= (ph_q == 5'd19) ? 5'd0 : ph_q + 5'd1;
            ref_pulse <= {2'b00, ph_q} < duty_pct / 7'd5;
        end
    end
endmodule
`default_nettype wire

// ---- dv/rifm_top_properties.sv ----
/* checker for bus, interrupt and exciter trip behaviour
   assumes it is bound into rifm_top */
`timescale 1ns/10ps
`default_nettype none
module rifm_props
    import rifm_pkg::*;
#(
    parameter int unsigned BLANK_CYC = 300,
    parameter int unsigned N_PINS    = 4
)(
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        exciter_sense_pos_ov,
    input wire logic        exciter_sense_neg_ov,
    input wire logic        exciter_out_en,
    input wire logic        fault_irq
);
    int   en_cnt;
    int   ov_cnt;
    logic wr_q;
    logic ctl_off;
    assign wr_q    = psel && penable && pwrite;
    assign ctl_off = wr_q && paddr == REG_CTRL_OFS && !pwdata[CTRL_EXC_EN_BIT];
    // ov_cnt only runs once blanking is surely over, so it never overstates
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_cnt <= 0;
            ov_cnt <= 0;
        end else begin
            en_cnt <= exciter_out_en ? en_cnt + (en_cnt < 1000000) : 0;
            ov_cnt <= ((exciter_sense_pos_ov || exciter_sense_neg_ov)
                       && en_cnt > BLANK_CYC + 4) ? ov_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_ctl_on;
        wr_q && paddr == REG_CTRL_OFS && pwdata[CTRL_EXC_EN_BIT];
    endsequence
    sequence s_mask_zero;
        wr_q && paddr == REG_MASK_OFS && pwdata == 32'h0000_0000;
    endsequence
    a_ready_always: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (psel && penable && paddr > REG_LIVE_OFS
        |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_mask_off_irq: assert property (s_mask_zero |-> ##2 !fault_irq)
        else $error("irq high with mask cleared");
    a_irq_after_rst: assert property ($rose(arst_n) |-> !fault_irq)
        else $error("irq high after reset");
    a_trip_bound: assert property (ov_cnt <= EXC_OV_DEGL_CYC + 8)
        else $error("exciter not cut on overvoltage");
    a_trip_not_early: assert property ($fell(exciter_out_en) && !$past(ctl_off)
        |-> $past(ov_cnt) >= EXC_OV_DEGL_CYC - 8)
        else $error("exciter cut too early");
    a_blank_quiet: assert property (exciter_out_en && en_cnt < BLANK_CYC
        && !ctl_off |=> exciter_out_en)
        else $error("exciter cut during blanking");
    a_ctrl_enable: assert property (s_ctl_on |-> ##[1:2] exciter_out_en)
        else $error("exciter enable not applied");
endmodule
bind rifm_top rifm_props #(.BLANK_CYC(BLANK_CYC), .N_PINS(N_PINS)) u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exciter_sense_pos_ov(exciter_sense_pos_ov),
    .exciter_sense_neg_ov(exciter_sense_neg_ov), .exciter_out_en(exciter_out_en),
    .fault_irq(fault_irq));
`default_nettype wire

// ---- dv/tb_rifm_top.sv ----
/* self-checking bench for the fault monitor top
   assumes zero-wait APB and a 25 MHz clock */
`timescale 1ns/10ps
`default_nettype none
module tb_rifm_top;
    import rifm_pkg::*;
    localparam int BLANK = 300;
    typedef struct { logic [24:0] cv; int sel; int d; } rifm_row_t;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, want;
    logic pready, pslverr, er, exciter_out_en, fault_irq, ref_pulse;
    logic [24:0] cv = 0;
    logic pos_ov = 0, neg_ov = 0;
    logic [6:0] duty = 7'd50;
    int num_errors = 0, checks = 0, lim;
    int dset[3] = '{90, 10, 50};
    logic [31:0] dexp[3] = '{32'h0020_0000, 32'h0040_0000, 32'h0000_0000};
    // cv bit 24 stands for the cosine mutual-short comparator
    rifm_row_t rows[11] = '{
        '{25'h000_000F, 0, 10}, '{25'h000_00F0, 1, -8},
        '{25'h000_00F0, 1, 10}, '{25'h000_0F00, 0, 10},
        '{25'h000_0F00, 0, -8}, '{25'h000_F000, 0, 10},
        '{25'h001_0000, 2, 10}, '{25'h100_0000, 2, 10},
        '{25'h00E_0000, 3, 10}, '{25'h00E_0000, 3, -8},
        '{25'h010_0000, 0, 10}};
    rifm_top #(.BLANK_CYC(BLANK)) dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_ov_high_cmp(cv[3:0]),
        .input_ov_low_cmp(cv[7:4]), .integrity_high_cmp(cv[11:8]),
        .integrity_low_cmp(cv[15:12]), .mutual_short_cmp({cv[24], cv[16]}),
        .sine_open_high_cmp(cv[17]), .cosine_open_high_cmp(cv[18]),
        .cosine_open_low_cmp(cv[19]), .loop_error_cmp(cv[20]),
        .ref_pulse(ref_pulse), .exciter_sense_pos_ov(pos_ov),
        .exciter_sense_neg_ov(neg_ov), .exciter_out_en(exciter_out_en),
        .fault_irq(fault_irq));
    rifm_ref_model u_ref (.sys_clk(sys_clk), .arst_n(arst_n), .duty_pct(duty),
        .ref_pulse(ref_pulse));
    always #20 sys_clk = ~sys_clk;
    task summarize;
        if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp_v);
        checks++;
        if (got !== exp_v) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp_v);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("BAD %0t apb no ready", $time);
            summarize();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wt(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    initial begin
        wt(6);
        arst_n <= 1'b1;
        apb(0, REG_CTRL_OFS, 0);
        chk(rd, CTRL_RST);
        apb(0, REG_DEGL_OFS, 0);
        chk(rd, DEGL_RST);
        apb(0, REG_MASK_OFS, 0);
        chk(rd, MASK_RST);
        apb(0, 8'h14, 0);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1, REG_MASK_OFS, 32'h00FF_FFFF);
        foreach (rows[i]) begin
            lim = rows[i].cv[15:8] != 0 ? INTEG_DEGL_CYC : (rows[i].sel + 1) * DEGL_STEP_CYC;
            want = rows[i].d < 0 ? 32'h0 : {8'h00, rows[i].cv[23:17],
                rows[i].cv[16] | rows[i].cv[24], rows[i].cv[15:0]};
            apb(1, REG_DEGL_OFS, 32'h0001_1111 * rows[i].sel);
            @(posedge sys_clk);
            cv <= rows[i].cv;
            wt(lim + rows[i].d);
            cv <= '0;
            wt(8);
            apb(0, REG_STAT_OFS, 0);
            chk(rd, want);
            chk({31'h0, fault_irq}, {31'h0, want != 0});
            apb(1, REG_STAT_OFS, 32'h00FF_FFFF);
            apb(0, REG_STAT_OFS, 0);
            chk(rd, 32'h0);
        end
        // ------------------------------
        // exciter blanking, duty, trip
        // ------------------------------
        apb(1, REG_DEGL_OFS, 32'h0);
        apb(1, REG_CTRL_OFS, 32'h0000_0001);
        pos_ov <= 1'b1;
        wt(BLANK - 20);
        pos_ov <= 1'b0;
        wt(40);
        chk({31'h0, exciter_out_en}, 32'h1);
        foreach (dset[k]) begin
            duty <= 7'd50;
            wt(2100);
            apb(1, REG_STAT_OFS, 32'h00FF_FFFF);
            duty <= 7'(dset[k]);
            wt(2100);
            apb(0, REG_STAT_OFS, 0);
            chk(rd, dexp[k]);
        end
        duty <= 7'd50;
        apb(1, REG_STAT_OFS, 32'h00FF_FFFF);
        neg_ov <= 1'b1;
        wt(EXC_OV_DEGL_CYC + 12);
        neg_ov <= 1'b0;
        wt(4);
        chk({31'h0, exciter_out_en}, 32'h0);
        apb(0, REG_STAT_OFS, 0);
        chk(rd & 32'h0080_0000, 32'h0080_0000);
        apb(1, REG_MASK_OFS, 32'h0);
        wt(2);
        chk({31'h0, fault_irq}, 32'h0);
        apb(1, REG_MASK_OFS, 32'h0080_0000);
        wt(2);
        chk({31'h0, fault_irq}, 32'h1);
        apb(1, REG_STAT_OFS, 32'h00FF_FFFF);
        wt(2);
        chk({31'h0, fault_irq}, 32'h0);
        apb(1, REG_CTRL_OFS, 32'h0000_0001);
        wt(BLANK + 20);
        pos_ov <= 1'b1;
        wt(EXC_OV_DEGL_CYC - 10);
        pos_ov <= 1'b0;
        wt(8);
        chk({31'h0, exciter_out_en}, 32'h1);
        // reset in mid-run must leave the drive and the interrupt low two cycles later
        arst_n <= 1'b0;
        wt(2);
        chk({30'h0, exciter_out_en, fault_irq}, 32'h0);
        arst_n <= 1'b1;
        apb(0, REG_CTRL_OFS, 0);
        chk(rd, CTRL_RST);
        summarize();
    end
endmodule
`default_nettype wire
